// File: common/gain_fader_pkg.sv
/*
  Constants for the audio path gain and fader block: register indices, field positions,
  reset values, gain codes and fade timing.
  Assumes a 200 MHz register clock and APB access with one register per aligned word.
*/
// Functional notes
// RULE1 - Capture gain is six bits: 0 is +31 dB, -1 dB per step, all ones mutes.
// RULE2 - Playback gain is six bits: 0 is 0 dB, down to -62 dB, all ones mutes.
// RULE3 - Bit six of capture and playback gains disables fading; change then applies at once.
// RULE4 - Loopbacks to the speaker drivers use playback coding with their own fade disable.
// RULE5 - Headset gain is four bits: 0 is +8 dB, 1000 is 0 dB, 1001 up mutes.
// RULE6 - Interpolator select bit: clear picks third-order sinc, set picks sample-and-hold.
// RULE7 - Software leaves interpolator select alone while any earpiece or headset converter runs.
// RULE8 - Fade speed field: 00 1 ms, 01 4 ms, 10 8 ms, 11 16 ms per step.
// RULE9 - One shared fade speed; each stage may still disable its own fading.
// RULE10 - Sidetone gain is five bits: 0 is 0 dB, down to -30 dB, all ones mutes.
// RULE11 - IIR pointer held at zero while IIR update is clear, unless first load runs.
// RULE12 - Noise cancel off refuses every FIR and IIR coefficient write.
// RULE13 - Setting the first-load bit starts IIR initialisation and opens first coefficient writes.
// RULE14 - FIR pointer held at zero while FIR update is clear; setting it releases it.
// RULE15 - A coefficient is high byte plus low byte; low byte write updates it.
// RULE16 - Fifteen FIR coefficients 0 to 14; pointer advances; bank applied after the last.
// RULE17 - Forty-four IIR coefficients 0 to 43 with update set; bank applied after the last.
// RULE18 - First IIR load: pulse first-load high then low, write 44 with update clear.
// RULE19 - While fading, applied gain steps one dB per fade interval toward the target.
// RULE20 - Reserved bits read back as written and do not touch the audio paths.

package gain_fader_pkg;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned FADE_BASE_NS = 1000000;
  localparam int unsigned MS_CYCLES = FADE_BASE_NS / CLK_PERIOD_NS;
  localparam logic [4:0] FADE_MS [4] = '{5'h01, 5'h04, 5'h08, 5'h10};

  // ----------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------------
  localparam logic [13:0] IDX_CAPTURE5_GAIN = 14'h0D45;
  localparam logic [13:0] IDX_CAPTURE6_GAIN = 14'h0D46;
  localparam logic [13:0] IDX_PLAYBACK1_GAIN = 14'h0D47;
  localparam logic [13:0] IDX_PLAYBACK2_GAIN = 14'h0D48;
  localparam logic [13:0] IDX_PLAYBACK3_GAIN = 14'h0D49;
  localparam logic [13:0] IDX_PLAYBACK4_GAIN = 14'h0D4A;
  localparam logic [13:0] IDX_PLAYBACK5_GAIN = 14'h0D4B;
  localparam logic [13:0] IDX_PLAYBACK6_GAIN = 14'h0D4C;
  localparam logic [13:0] IDX_LOOP1_LEFT_SPEAKER_GAIN = 14'h0D4D;
  localparam logic [13:0] IDX_LOOP2_RIGHT_SPEAKER_GAIN = 14'h0D4E;
  localparam logic [13:0] IDX_HEADSET_LEFT_EARPIECE_GAIN = 14'h0D4F;
  localparam logic [13:0] IDX_HEADSET_RIGHT_GAIN = 14'h0D50;
  localparam logic [13:0] IDX_SIDETONE1_GAIN = 14'h0D51;
  localparam logic [13:0] IDX_SIDETONE2_GAIN = 14'h0D52;
  localparam logic [13:0] IDX_NOISE_CANCEL_CONTROL = 14'h0D53;
  localparam logic [13:0] IDX_NOISE_CANCEL_INPUT_SHIFT = 14'h0D54;
  localparam logic [13:0] IDX_FIR_COEF_HIGH = 14'h0D57;
  localparam logic [13:0] IDX_FIR_COEF_LOW = 14'h0D58;
  localparam logic [13:0] IDX_IIR_COEF_HIGH = 14'h0D59;
  localparam logic [13:0] IDX_IIR_COEF_LOW = 14'h0D5A;
  localparam logic [13:0] IDX_LOADER_STATUS = 14'h0D70;

  localparam int unsigned NUM_CFG = 16;
  localparam int unsigned NUM_STAGES = 12;
  localparam int unsigned NUM_SIX_BIT = 10;
  localparam int unsigned OFS_HS_RIGHT = 11;
  localparam int unsigned OFS_SIDETONE1 = 12;
  localparam int unsigned OFS_SIDETONE2 = 13;
  localparam int unsigned OFS_NC_CONTROL = 14;
  localparam int unsigned OFS_NC_SHIFT = 15;

  localparam logic [7:0] CFG_RESET [NUM_CFG] = '{
    8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F,
    8'h3F, 8'h3F, 8'h0F, 8'h0F, 8'h1F, 8'h1F, 8'h00, 8'h00};

  // ----------------------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------------------
  localparam int unsigned FADE_OFF_BIT = 6;
  localparam int unsigned HS_FADE_OFF_BIT = 4;
  localparam int unsigned INTERP_BIT = 7;
  localparam int unsigned FADE_SPEED_LSB = 6;
  localparam int unsigned NC_IIR_RELEASE_BIT = 3;
  localparam int unsigned NC_ON_BIT = 2;
  localparam int unsigned NC_FIRST_LOAD_BIT = 1;
  localparam int unsigned NC_FIR_RELEASE_BIT = 0;
  localparam logic [5:0] MUTE_SIX = 6'h3F;
  localparam logic [5:0] MUTE_HEADSET = 6'h09;
  localparam logic [4:0] MUTE_SIDETONE = 5'h1F;
  localparam logic [5:0] FIR_LAST = 6'h0E;
  localparam logic [5:0] IIR_LAST = 6'h2B;

endpackage

// File: core/audio_path_gain_fader.sv
/*
  Gain and fade control for capture, playback, loopback and headset stages, gain control for sidetone stages,
  plus the noise-cancel coefficient loader, behind an APB slave.
  Assumes synchronous inputs on pclk and a coefficient store outside that takes coef_we.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps

module audio_path_gain_fader #(
  parameter int unsigned MS_CYCLES = gain_fader_pkg::MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [11:0][5:0] stage_code,
  output logic [11:0] stage_mute,
  output logic [4:0] sidetone1_gain_code,
  output logic [4:0] sidetone2_gain_code,
  output logic [1:0] sidetone_mute,
  output logic hold_interpolator_select,
  output logic noise_cancel_on,
  output logic [4:0] nc_input_shift,
  output logic coef_we,
  output logic coef_is_iir,
  output logic [5:0] coef_index,
  output logic [15:0] coef_data,
  output logic fir_bank_apply,
  output logic iir_bank_apply
);

  // ----------------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------------
  logic [7:0] cfg_reg [gain_fader_pkg::NUM_CFG];
  logic [7:0] fir_high_reg;
  logic [7:0] fir_low_reg;
  logic [7:0] iir_high_reg;
  logic [7:0] iir_low_reg;
  logic [5:0] fir_ptr_reg;
  logic [5:0] iir_ptr_reg;
  logic iir_armed_reg;
  logic [31:0] prdata_reg;
  logic [13:0] idx;
  logic [13:0] cfg_ofs;
  logic in_cfg;
  logic mapped;
  logic access;
  logic wr_en;
  logic [31:0] rd_value;
  logic fading;

  assign idx = paddr[15:2];
  assign cfg_ofs = idx - gain_fader_pkg::IDX_CAPTURE5_GAIN;
  assign in_cfg = (idx >= gain_fader_pkg::IDX_CAPTURE5_GAIN) &&
                  (idx <= gain_fader_pkg::IDX_NOISE_CANCEL_INPUT_SHIFT);
  assign access = psel && penable;
  assign pready = 1'b1;
  assign prdata = prdata_reg;

  always_comb begin
    mapped = paddr[1:0] == 2'b00;
    rd_value = 32'h0000_0000;
    if (in_cfg) begin
      rd_value = {24'h00_0000, cfg_reg[cfg_ofs[3:0]]}; // [RULE20]
    end else begin
      unique case (idx)
        gain_fader_pkg::IDX_FIR_COEF_HIGH: rd_value = {24'h00_0000, fir_high_reg};
        gain_fader_pkg::IDX_FIR_COEF_LOW: rd_value = {24'h00_0000, fir_low_reg};
        gain_fader_pkg::IDX_IIR_COEF_HIGH: rd_value = {24'h00_0000, iir_high_reg};
        gain_fader_pkg::IDX_IIR_COEF_LOW: rd_value = {24'h00_0000, iir_low_reg};
        gain_fader_pkg::IDX_LOADER_STATUS: begin
          rd_value = {14'h0000, fading, iir_armed_reg, 2'b00, iir_ptr_reg, 2'b00, fir_ptr_reg};
        end
        default: mapped = 1'b0;
      endcase
    end
  end

  assign pslverr = access && !mapped;
  assign wr_en = access && pwrite && mapped;

  // The read word is captured in the setup cycle so the access phase answers at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_value;
    end
  end

  // ----------------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < gain_fader_pkg::NUM_CFG; i++) begin
        cfg_reg[i] <= gain_fader_pkg::CFG_RESET[i];
      end
    end else if (wr_en && in_cfg) begin
      cfg_reg[cfg_ofs[3:0]] <= pwdata[7:0]; // [RULE20]
    end
  end

  logic [7:0] nc_ctrl;
  logic nc_fir_load_release;
  logic nc_iir_load_release;
  logic nc_iir_first_load;

  assign nc_ctrl = cfg_reg[gain_fader_pkg::OFS_NC_CONTROL];
  assign nc_fir_load_release = nc_ctrl[gain_fader_pkg::NC_FIR_RELEASE_BIT];
  assign nc_iir_load_release = nc_ctrl[gain_fader_pkg::NC_IIR_RELEASE_BIT];
  assign nc_iir_first_load = nc_ctrl[gain_fader_pkg::NC_FIRST_LOAD_BIT];

  // ----------------------------------------------------------------------------
  // Static outputs
  // ----------------------------------------------------------------------------
  // Interpolator select is passed straight through; changing it with a converter
  // running is a software fault that this block does not guard against. [RULE7]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_interpolator_select <= 1'b0;
      noise_cancel_on <= 1'b0;
      nc_input_shift <= 5'h00;
      sidetone1_gain_code <= gain_fader_pkg::MUTE_SIDETONE;
      sidetone2_gain_code <= gain_fader_pkg::MUTE_SIDETONE;
      sidetone_mute <= 2'b11;
    end else begin
      hold_interpolator_select <= cfg_reg[10][gain_fader_pkg::INTERP_BIT]; // [RULE6]
      noise_cancel_on <= nc_ctrl[gain_fader_pkg::NC_ON_BIT]; // [RULE12]
      nc_input_shift <= cfg_reg[gain_fader_pkg::OFS_NC_SHIFT][4:0];
      sidetone1_gain_code <= cfg_reg[gain_fader_pkg::OFS_SIDETONE1][4:0]; // [RULE10]
      sidetone2_gain_code <= cfg_reg[gain_fader_pkg::OFS_SIDETONE2][4:0]; // [RULE10]
      sidetone_mute[0] <= cfg_reg[gain_fader_pkg::OFS_SIDETONE1][4:0] ==
                          gain_fader_pkg::MUTE_SIDETONE; // [RULE10]
      sidetone_mute[1] <= cfg_reg[gain_fader_pkg::OFS_SIDETONE2][4:0] ==
                          gain_fader_pkg::MUTE_SIDETONE; // [RULE10]
    end
  end

  // ----------------------------------------------------------------------------
  // Fade timebase
  // ----------------------------------------------------------------------------
  logic [31:0] ms_cnt_reg;
  logic [4:0] step_cnt_reg;
  logic ms_tick;
  logic fade_tick;
  logic [4:0] step_last;

  assign ms_tick = ms_cnt_reg == MS_CYCLES - 1;
  assign step_last = gain_fader_pkg::FADE_MS[cfg_reg[gain_fader_pkg::OFS_HS_RIGHT]
                     [gain_fader_pkg::FADE_SPEED_LSB +: 2]] - 5'h01; // [RULE8]
  assign fade_tick = ms_tick && (step_cnt_reg >= step_last); // [RULE9]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else if (ms_tick) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
    end
  end

  // A speed change mid-interval takes effect at the next millisecond, so no step is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_reg <= 5'h00;
    end else if (fade_tick) begin
      step_cnt_reg <= 5'h00;
    end else if (ms_tick) begin
      step_cnt_reg <= step_cnt_reg + 5'h01; // [RULE8]
    end
  end

  // ----------------------------------------------------------------------------
  // Faded stages: 0-1 capture, 2-7 playback, 8-9 loopback, 10-11 headset
  // ----------------------------------------------------------------------------
  logic [11:0][5:0] target;
  logic [11:0] fade_off;

  genvar g;
  generate
    for (g = 0; g < gain_fader_pkg::NUM_STAGES; g++) begin : g_stage
      if (g < gain_fader_pkg::NUM_SIX_BIT) begin : g_six
        // Capture, playback and loopback share code layout; only the dB meaning differs.
        assign target[g] = cfg_reg[g][5:0]; // [RULE1] [RULE2] [RULE4]
        assign fade_off[g] = cfg_reg[g][gain_fader_pkg::FADE_OFF_BIT]; // [RULE3] [RULE4]
        assign stage_mute[g] = stage_code[g] == gain_fader_pkg::MUTE_SIX; // [RULE1] [RULE2]
      end else begin : g_hs
        // All mute codes of the headset collapse onto one so the fade has a single end.
        assign target[g] = (cfg_reg[g][3:0] >= gain_fader_pkg::MUTE_HEADSET[3:0]) ?
                           gain_fader_pkg::MUTE_HEADSET : {2'b00, cfg_reg[g][3:0]}; // [RULE5]
        assign fade_off[g] = cfg_reg[g][gain_fader_pkg::HS_FADE_OFF_BIT];
        assign stage_mute[g] = stage_code[g] == gain_fader_pkg::MUTE_HEADSET; // [RULE5]
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage_code[g] <= (g < gain_fader_pkg::NUM_SIX_BIT) ?
                           gain_fader_pkg::MUTE_SIX : gain_fader_pkg::MUTE_HEADSET;
        end else if (fade_off[g]) begin
          stage_code[g] <= target[g]; // [RULE3]
        end else if (fade_tick && stage_code[g] < target[g]) begin
          stage_code[g] <= stage_code[g] + 6'h01; // [RULE19]
        end else if (fade_tick && stage_code[g] > target[g]) begin
          stage_code[g] <= stage_code[g] - 6'h01; // [RULE19]
        end
      end
    end
  endgenerate

  assign fading = stage_code != target;

  // ----------------------------------------------------------------------------
  // Noise-cancel coefficient loader
  // ----------------------------------------------------------------------------
  logic fir_low_wr;
  logic iir_low_wr;
  logic iir_open;
  logic fir_accept;
  logic iir_accept;

  assign fir_low_wr = wr_en && idx == gain_fader_pkg::IDX_FIR_COEF_LOW;
  assign iir_low_wr = wr_en && idx == gain_fader_pkg::IDX_IIR_COEF_LOW;
  assign iir_open = nc_iir_load_release || iir_armed_reg; // [RULE11]
  assign fir_accept = fir_low_wr && noise_cancel_on && nc_fir_load_release; // [RULE12]
  assign iir_accept = iir_low_wr && noise_cancel_on && iir_open; // [RULE12]

  // Byte registers are kept only while noise cancel is on, even for low-byte writes the loader then refuses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fir_high_reg <= 8'h00;
      fir_low_reg <= 8'h00;
      iir_high_reg <= 8'h00;
      iir_low_reg <= 8'h00;
    end else if (wr_en && noise_cancel_on) begin // [RULE12]
      unique case (idx)
        gain_fader_pkg::IDX_FIR_COEF_HIGH: fir_high_reg <= pwdata[7:0];
        gain_fader_pkg::IDX_FIR_COEF_LOW: fir_low_reg <= pwdata[7:0];
        gain_fader_pkg::IDX_IIR_COEF_HIGH: iir_high_reg <= pwdata[7:0];
        gain_fader_pkg::IDX_IIR_COEF_LOW: iir_low_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fir_ptr_reg <= 6'h00;
    end else if (!nc_fir_load_release) begin
      fir_ptr_reg <= 6'h00; // [RULE14]
    end else if (fir_accept) begin
      fir_ptr_reg <= (fir_ptr_reg == gain_fader_pkg::FIR_LAST) ? 6'h00 :
                     fir_ptr_reg + 6'h01; // [RULE16]
    end
  end

  // First-load window: opened by the first-load bit, kept after it falls, closed by the
  // forty-fourth word. The set wins over the close in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iir_armed_reg <= 1'b0;
    end else if (nc_iir_first_load) begin
      iir_armed_reg <= 1'b1; // [RULE13] [RULE18]
    end else if (iir_accept && iir_ptr_reg == gain_fader_pkg::IIR_LAST) begin
      iir_armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iir_ptr_reg <= 6'h00;
    end else if (!iir_open) begin
      iir_ptr_reg <= 6'h00; // [RULE11]
    end else if (iir_accept) begin
      iir_ptr_reg <= (iir_ptr_reg == gain_fader_pkg::IIR_LAST) ? 6'h00 :
                     iir_ptr_reg + 6'h01; // [RULE17]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coef_we <= 1'b0;
      coef_is_iir <= 1'b0;
      coef_index <= 6'h00;
      coef_data <= 16'h0000;
      fir_bank_apply <= 1'b0;
      iir_bank_apply <= 1'b0;
    end else begin
      coef_we <= fir_accept || iir_accept; // [RULE15]
      fir_bank_apply <= fir_accept && fir_ptr_reg == gain_fader_pkg::FIR_LAST; // [RULE16]
      iir_bank_apply <= iir_accept && iir_ptr_reg == gain_fader_pkg::IIR_LAST; // [RULE17]
      if (fir_accept) begin
        coef_is_iir <= 1'b0;
        coef_index <= fir_ptr_reg;
        coef_data <= {fir_high_reg, pwdata[7:0]}; // [RULE15]
      end else if (iir_accept) begin
        coef_is_iir <= 1'b1;
        coef_index <= iir_ptr_reg;
        coef_data <= {iir_high_reg, pwdata[7:0]}; // [RULE15]
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  sequence s_play1_write_nofade;
    wr_en && idx == gain_fader_pkg::IDX_PLAYBACK1_GAIN && pwdata[6];
  endsequence

  sequence s_fir_last_word;
    fir_accept && fir_ptr_reg == gain_fader_pkg::FIR_LAST;
  endsequence

  sequence s_iir_last_word;
    iir_accept && iir_ptr_reg == gain_fader_pkg::IIR_LAST;
  endsequence

  a_fade_off_direct: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
    s_play1_write_nofade |-> ##2 stage_code[2] == $past(pwdata[5:0], 2))
    else $error("Unfaded playback gain did not apply directly.");

  a_fade_one_step: assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
    (fade_tick && !fade_off[3] && stage_code[3] != target[3]) |=>
    (stage_code[3] == $past(stage_code[3]) + 6'h01 ||
     stage_code[3] == $past(stage_code[3]) - 6'h01))
    else $error("Faded playback gain did not move by one step.");

  a_fade_hold_still: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    (!fade_tick && !fade_off[3] && !$changed(target[3])) |=> $stable(stage_code[3]))
    else $error("Faded playback gain moved between fade steps.");

  a_fade_tick_slot: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    fade_tick |=> ms_cnt_reg == 32'h0000_0000 && step_cnt_reg == 5'h00)
    else $error("Fade interval counters did not restart after a step.");

  a_fir_ptr_held: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    !nc_fir_load_release |=> fir_ptr_reg == 6'h00)
    else $error("FIR pointer left zero while released bit clear.");

  a_iir_ptr_held: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
    !iir_open |=> iir_ptr_reg == 6'h00)
    else $error("IIR pointer left zero while closed.");

  a_nc_off_refuse: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    ((fir_low_wr || iir_low_wr) && !noise_cancel_on) |=> !coef_we)
    else $error("Coefficient write taken with noise cancel off.");

  a_coef_pairing: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    fir_accept |=> coef_we && coef_data == {$past(fir_high_reg), $past(pwdata[7:0])})
    else $error("FIR coefficient word mispaired.");

  a_fir_bank_end: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
    s_fir_last_word |=> fir_bank_apply ##1 !fir_bank_apply && fir_ptr_reg == 6'h00)
    else $error("FIR bank not applied once after last word.");

  a_iir_bank_end: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    s_iir_last_word |=> iir_bank_apply && coef_index == 6'h2B)
    else $error("IIR bank not applied after word forty-three.");

  a_hs_mute_code: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    (fade_off[10] && cfg_reg[10][3:0] >= 4'h9) |=> stage_mute[10])
    else $error("Headset mute code did not mute.");

endmodule

// File: tb/coef_store_model.sv
/*
  Model of the coefficient store behind the noise-cancel loader.
  Assumes the coef_* pulses of the gain block, synchronous to pclk.
*/
`timescale 1ns/100ps
module coef_store_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic coef_we,
  input wire logic coef_is_iir,
  input wire logic [5:0] coef_index,
  input wire logic [15:0] coef_data,
  input wire logic fir_bank_apply,
  input wire logic iir_bank_apply
);
  logic [15:0] fir_mem [15];
  logic [15:0] iir_mem [44];
  int words;
  int fir_banks;
  int iir_banks;
  // Out-of-range indices are dropped, as a real store would ignore them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      words <= 0;
      fir_banks <= 0;
      iir_banks <= 0;
    end else if (coef_we) begin
      words <= words + 1;
      if (coef_is_iir) iir_mem[coef_index] <= coef_data;
      else fir_mem[coef_index] <= coef_data;
      fir_banks <= fir_banks + int'(fir_bank_apply);
      iir_banks <= iir_banks + int'(iir_bank_apply);
    end
  end
endmodule

// File: tb/test_audio_path_gain_fader.sv
/*
  Self-checking bench for the gain and fader block.
  Assumes an APB master here and the coefficient store model on coef_*.
*/
`timescale 1ns/100ps
module test_audio_path_gain_fader;
  localparam logic [13:0] G0 = gain_fader_pkg::IDX_CAPTURE5_GAIN;
  localparam logic [13:0] CTL = gain_fader_pkg::IDX_NOISE_CANCEL_CONTROL;
  localparam logic [13:0] FH = gain_fader_pkg::IDX_FIR_COEF_HIGH;
  localparam logic [13:0] FL = gain_fader_pkg::IDX_FIR_COEF_LOW;
  localparam logic [13:0] IL = gain_fader_pkg::IDX_IIR_COEF_LOW;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0][5:0] stage_code;
  logic [11:0] stage_mute;
  logic [4:0] sidetone1_gain_code, sidetone2_gain_code, nc_input_shift;
  logic [1:0] sidetone_mute;
  logic hold_interpolator_select, noise_cancel_on, coef_we, coef_is_iir;
  logic fir_bank_apply, iir_bank_apply;
  logic [5:0] coef_index;
  logic [15:0] coef_data;
  int bad_count, compares;
  logic [7:0] wv [12] = '{8'hC0, 8'hFF, 8'hC1, 8'hFE, 8'hDF, 8'hC0,
    8'hE0, 8'hFE, 8'hC5, 8'hFF, 8'h1A, 8'h18};
  logic [5:0] ex [12] = '{6'h00, 6'h3F, 6'h01, 6'h3E, 6'h1F, 6'h00,
    6'h20, 6'h3E, 6'h05, 6'h3F, 6'h09, 6'h08};
  // Short fade timebase keeps the fade scenarios to a few hundred cycles.
  audio_path_gain_fader #(.MS_CYCLES(20)) audio_path_gain_fader_i (.*);
  coef_store_model coef_store_model_i (.*);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_cy(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic final_report;
    $display("Compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    final_report;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    bad_count = 0;
    compares = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("mute_rst", 32'hFFF, 32'(stage_mute));
    chk("st_rst", 32'h3, 32'(sidetone_mute));
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, G0 + 14'(i), 8'h00);
      chk("reset", 32'(gain_fader_pkg::CFG_RESET[i]), rd);
    end
    for (int i = 0; i < 12; i++) begin
      apb(1'b1, G0 + 14'(i), wv[i]);
      wait_cy(2);
      chk("code", 32'(ex[i]), 32'(stage_code[i]));
      chk("mute", 32'(ex[i] == (i < 10 ? 6'h3F : 6'h09)), 32'(stage_mute[i]));
      apb(1'b0, G0 + 14'(i), 8'h00);
      chk("readback", 32'(wv[i]), rd);
    end
    apb(1'b1, G0 + 14'd3, 8'h3B);
    wait_cy(2);
    chk("no_jump", 1, 32'(stage_code[3] !== 6'h3B));
    wait_cy(100);
    chk("fade_fast", 32'h3B, 32'(stage_code[3]));
    apb(1'b1, G0 + 14'd11, 8'h58);
    apb(1'b1, G0 + 14'd3, 8'h3F);
    wait_cy(200);
    chk("fade_slow", 1, 32'(stage_code[3] !== 6'h3F));
    wait_cy(200);
    chk("fade_end", 32'h3F, 32'(stage_code[3]));
    apb(1'b1, G0 + 14'd10, 8'h98);
    apb(1'b1, G0 + 14'd12, 8'hFE);
    apb(1'b1, G0 + 14'd15, 8'hF3);
    wait_cy(2);
    chk("interp", 1, 32'(hold_interpolator_select));
    chk("st_code", 32'h1E, 32'(sidetone1_gain_code));
    chk("st_mute", 32'h2, 32'(sidetone_mute));
    chk("st2_code", 32'h1F, 32'(sidetone2_gain_code));
    chk("shift", 32'h13, 32'(nc_input_shift));
    apb(1'b0, 14'h0D71, 8'h00);
    chk("unmapped", 32'h1, 32'(er));
    chk("unmapped_rd", 0, rd);
    apb(1'b1, CTL, 8'h01);
    apb(1'b1, FL, 8'h34);
    wait_cy(2);
    chk("nc_off", 0, coef_store_model_i.words);
    apb(1'b1, CTL, 8'h05);
    apb(1'b1, FH, 8'h12);
    chk("nc_on", 1, 32'(noise_cancel_on));
    for (int k = 0; k < 3; k++) apb(1'b1, FL, 8'(k + 64));
    apb(1'b0, gain_fader_pkg::IDX_LOADER_STATUS, 8'h00);
    chk("fir_ptr", 32'h3, rd);
    apb(1'b1, CTL, 8'h04);
    apb(1'b1, CTL, 8'h05);
    for (int k = 0; k < 15; k++) apb(1'b1, FL, 8'(k));
    wait_cy(2);
    chk("fir_first", 32'h1200, 32'(coef_store_model_i.fir_mem[0]));
    chk("fir_last", 32'h120E, 32'(coef_store_model_i.fir_mem[14]));
    chk("fir_bank", 1, coef_store_model_i.fir_banks);
    apb(1'b1, CTL, 8'h06);
    apb(1'b1, CTL, 8'h04);
    apb(1'b1, IL - 14'd1, 8'hAB);
    for (int k = 0; k < 44; k++) apb(1'b1, IL, 8'(k));
    apb(1'b1, IL, 8'h55);
    wait_cy(2);
    chk("iir_last", 32'hAB2B, 32'(coef_store_model_i.iir_mem[43]));
    chk("iir_bank", 1, coef_store_model_i.iir_banks);
    chk("iir_held", 62, coef_store_model_i.words);
    apb(1'b1, CTL, 8'h0C);
    for (int k = 0; k < 44; k++) apb(1'b1, IL, 8'(k + 100));
    wait_cy(2);
    chk("iir_upd", 32'hAB8F, 32'(coef_store_model_i.iir_mem[43]));
    chk("iir_bank2", 2, coef_store_model_i.iir_banks);
    chk("coef_index", 32'h2B, 32'(coef_index));
    chk("coef_is_iir", 1, 32'(coef_is_iir));
    presetn <= 1'b0;
    wait_cy(2);
    presetn <= 1'b1;
    wait_cy(1);
    chk("mute_rst2", 32'hFFF, 32'(stage_mute));
    chk("words_rst2", 0, coef_store_model_i.words);
    apb(1'b0, G0, 8'h00);
    chk("reset2", 32'h3F, rd);
    final_report;
  end
endmodule
